// [tuner_cfg.svh]
// register map, field positions and link framing for the tuner readback bank
// assumes 32-bit classic wishbone with byte addresses, word index in adr[7:2]
`ifndef TUNER_CFG_SVH
`define TUNER_CFG_SVH
`define IDX_CTRL 6'h02
`define IDX_STATUS 6'h0a
`define IDX_REQUESTED_CHANNEL 6'h0b
`define IDX_BLK_A 6'h0c
`define IDX_BLK_B 6'h0d
`define IDX_BLK_C 6'h0e
`define IDX_BLK_D 6'h0f
`define IDX_IRQ_STAT 6'h10
`define IDX_IRQ_MASK 6'h11
`define IDX_FREQ 6'h12
`define CTRL_VERBOSE 11
`define CTRL_TUNE 9
`define CTRL_SEEK 8
`define CTRL_BAND_LSB 6
`define CTRL_SPACE_LSB 4
`define CTRL_GPIO_LSB 0
`define ST_READY_BIT 15
`define ST_STC_BIT 14
`define ST_STEREO_BIT 8
`define GPIO_FN_STEREO 2'h1
`define SIGNAL_STRENGTH_LEVEL_MAX 8'h4b
`define BAND_WIDE 2'h0
`define BASE_WIDE 16'h222e
`define BASE_LOW 16'h1db0
`define SPACE_WIDE 5'h14
`define SPACE_MID 5'h0a
`define SPACE_NARROW 5'h05
`define LINK_BITS 7'h46
`define IRQ_GROUP 0
`define IRQ_STC 1
`endif

// [tuner_pkg.sv]
// types shared by the tuner readback bank
// field positions and counts live in tuner_cfg.svh
package tuner_pkg;
    typedef enum logic [2:0] {
        LINK_IDLE = 3'b001,
        LINK_SHIFT = 3'b010,
        LINK_COMMIT = 3'b100
    } linkState_t;
    typedef struct packed {
        logic verbose;
        logic tune;
        logic seek;
        logic [1:0] band;
        logic [1:0] spacing;
        logic [1:0] gpioFn;
    } ctrl_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wbReq_t;
    typedef struct packed {
        ctrl_t ctrl;
        logic [1:0] irqStat;
        logic [1:0] irqMask;
        logic seek_tune_complete_flag;
        logic stereo;
        logic [7:0] signal_strength_level;
        logic [9:0] requested_channel;
        logic [3:0][15:0] blk;
        logic [2:0][1:0] grade;
        logic [69:0] shift;
        logic [6:0] bitCnt;
        linkState_t link;
        logic [1:0] clkS;
        logic [1:0] datS;
        logic [1:0] frmS;
        logic clkPrev;
        logic ack;
        logic [31:0] rdData;
    } state_t;
endpackage : tuner_pkg

// [tuner_status_rds_readback.sv]
// status, tuned channel and broadcast block readback bank with wishbone slave
// assumes tuner core signals on sys_clk; block link pins asynchronous
// How it works
// - stereo bit 8 of status; third pin shows it when its function is 01
// - eight-bit signal level in bits 7:0, saturated at 75
// - grades of blocks B, C, D sit in bits 15:14, 13:12, 11:10
// - grades read as zero unless verbose reporting mode is set
// - band 00: frequency is spacing times channel plus 87.5 MHz
// - band 01 or 10: frequency is spacing times channel plus 76 MHz
// - tuned channel follows the core during seek and on completion
// - four block words readable as separate 16-bit registers
// - complete flag set on finish, cleared when seek or tune goes low
// - group-ready flag set when a new group lands
`timescale 1ns/1ps
`default_nettype none
`include "tuner_cfg.svh"
module tuner_status_rds_readback (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    // tuner core, same clock
    input wire logic stereoIn,
    input wire logic [7:0] rssiIn,
    input wire logic [9:0] chanIn,
    input wire logic seekActive,
    input wire logic opDone,
    // block data link pins
    input wire logic blkLinkClk,
    input wire logic blkLinkData,
    input wire logic blkLinkFrame,
    // third general pin
    output logic thirdGeneralPinOut,
    output logic thirdGeneralPinOe,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] satLevel(input logic [7:0] v);
        satLevel = (v > `SIGNAL_STRENGTH_LEVEL_MAX) ? `SIGNAL_STRENGTH_LEVEL_MAX : v;
    endfunction : satLevel

    // frequency in 10 kHz units so every spacing is a whole step
    function automatic logic [15:0] freqOf(input logic [1:0] band,
            input logic [1:0] space, input logic [9:0] requested_channel);
        logic [4:0] step;
        logic [15:0] base;
        step = (space == 2'h0) ? `SPACE_WIDE :
               (space == 2'h1) ? `SPACE_MID : `SPACE_NARROW;
        base = (band == `BAND_WIDE) ? `BASE_WIDE : `BASE_LOW;
        freqOf = 16'(step) * 16'(requested_channel) + base;
    endfunction : freqOf

    // byte lanes: only the low two carry register bits
    function automatic logic [15:0] lanes(input logic [15:0] old,
            input logic [31:0] d, input logic [3:0] sel);
        lanes = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : lanes

    ////////////////////////////////////////////////////////////////////////
    tuner_pkg::state_t st_r;
    tuner_pkg::state_t st_nxt;
    tuner_pkg::wbReq_t req;
    logic [15:0] ctrlWord;
    logic [15:0] gradeField;
    logic [15:0] nextCtrl;
    logic linkRise;
    logic wrHit;
    logic [5:0] idx;

    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, sel: sel_i, dat: dat_i};
    assign idx = req.adr[7:2];
    assign linkRise = st_r.clkS[1] & ~st_r.clkPrev;
    assign wrHit = req.cyc & req.stb & req.we & st_r.ack;

    always_comb begin
        ctrlWord = 16'h0000;
        ctrlWord[`CTRL_VERBOSE] = st_r.ctrl.verbose;
        ctrlWord[`CTRL_TUNE] = st_r.ctrl.tune;
        ctrlWord[`CTRL_SEEK] = st_r.ctrl.seek;
        ctrlWord[`CTRL_BAND_LSB +: 2] = st_r.ctrl.band;
        ctrlWord[`CTRL_SPACE_LSB +: 2] = st_r.ctrl.spacing;
        ctrlWord[`CTRL_GPIO_LSB +: 2] = st_r.ctrl.gpioFn;
        nextCtrl = lanes(ctrlWord, req.dat, req.sel);
        // grade fields hidden unless verbose
        gradeField = st_r.ctrl.verbose ? {st_r.grade, 10'h000} : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        // pin synchronisers and edge finder
        // link pins come from another clock: two flops before any use
        st_nxt.clkS = {st_r.clkS[0], blkLinkClk};
        st_nxt.datS = {st_r.datS[0], blkLinkData};
        st_nxt.frmS = {st_r.frmS[0], blkLinkFrame};
        st_nxt.clkPrev = st_r.clkS[1];
        // tuner core status
        st_nxt.stereo = stereoIn;
        st_nxt.signal_strength_level = satLevel(rssiIn);
        if (seekActive || opDone) begin
            st_nxt.requested_channel = chanIn;
        end
        // block link framing
        case (st_r.link)
            tuner_pkg::LINK_IDLE: begin
                st_nxt.bitCnt = 7'h00;
                if (st_r.frmS[1]) begin
                    st_nxt.link = tuner_pkg::LINK_SHIFT;
                end
            end
            tuner_pkg::LINK_SHIFT: begin
                if (!st_r.frmS[1]) begin
                    st_nxt.link = (st_r.bitCnt == `LINK_BITS) ?
                        tuner_pkg::LINK_COMMIT : tuner_pkg::LINK_IDLE;
                end else if (linkRise) begin
                    st_nxt.shift = {st_r.shift[68:0], st_r.datS[1]};
                    // count sticks at its top so a long frame never wraps to a good one
                    if (st_r.bitCnt != 7'h7f) begin
                        st_nxt.bitCnt = st_r.bitCnt + 7'h01;
                    end
                end
            end
            tuner_pkg::LINK_COMMIT: begin
                // whole group moves in one cycle so a read never sees a mix
                st_nxt.blk = st_r.shift[69:6];
                st_nxt.grade = st_r.shift[5:0];
                st_nxt.link = tuner_pkg::LINK_IDLE;
            end
            default: begin
                st_nxt.link = tuner_pkg::LINK_IDLE;
            end
        endcase
        // wishbone: ack one cycle after request, writes at the acked edge
        st_nxt.ack = req.cyc & req.stb & ~st_r.ack;
        // read data latched when taken, stands with ack
        if (req.cyc && req.stb && !st_r.ack) begin
            case (idx)
                `IDX_CTRL: st_nxt.rdData = {16'h0000, ctrlWord};
                `IDX_STATUS: st_nxt.rdData = {16'h0000, st_r.irqStat[`IRQ_GROUP],
                    st_r.seek_tune_complete_flag, 5'h00, st_r.stereo, st_r.signal_strength_level};
                `IDX_REQUESTED_CHANNEL: st_nxt.rdData = {16'h0000, gradeField[15:10], st_r.requested_channel};
                `IDX_BLK_A: st_nxt.rdData = {16'h0000, st_r.blk[3]};
                `IDX_BLK_B: st_nxt.rdData = {16'h0000, st_r.blk[2]};
                `IDX_BLK_C: st_nxt.rdData = {16'h0000, st_r.blk[1]};
                `IDX_BLK_D: st_nxt.rdData = {16'h0000, st_r.blk[0]};
                `IDX_IRQ_STAT: st_nxt.rdData = {30'h0000_0000, st_r.irqStat};
                `IDX_IRQ_MASK: st_nxt.rdData = {30'h0000_0000, st_r.irqMask};
                `IDX_FREQ: st_nxt.rdData = {16'h0000,
                    freqOf(st_r.ctrl.band, st_r.ctrl.spacing, st_r.requested_channel)};
                default: st_nxt.rdData = 32'h0000_0000;
            endcase
        end
        if (wrHit) begin
            case (idx)
                `IDX_CTRL: begin
                    st_nxt.ctrl.verbose = nextCtrl[`CTRL_VERBOSE];
                    st_nxt.ctrl.tune = nextCtrl[`CTRL_TUNE];
                    st_nxt.ctrl.seek = nextCtrl[`CTRL_SEEK];
                    st_nxt.ctrl.band = nextCtrl[`CTRL_BAND_LSB +: 2];
                    st_nxt.ctrl.spacing = nextCtrl[`CTRL_SPACE_LSB +: 2];
                    st_nxt.ctrl.gpioFn = nextCtrl[`CTRL_GPIO_LSB +: 2];
                    if ((st_r.ctrl.seek && !nextCtrl[`CTRL_SEEK]) ||
                            (st_r.ctrl.tune && !nextCtrl[`CTRL_TUNE])) begin
                        st_nxt.seek_tune_complete_flag = 1'b0;
                    end
                end
                `IDX_IRQ_STAT: begin
                    if (req.sel[0]) begin
                        st_nxt.irqStat = st_r.irqStat & ~req.dat[1:0];
                    end
                end
                `IDX_IRQ_MASK: begin
                    if (req.sel[0]) begin
                        st_nxt.irqMask = req.dat[1:0];
                    end
                end
                default: begin
                    st_nxt.irqMask = st_r.irqMask;
                end
            endcase
        end
        // events win over a clear in the same cycle
        if (opDone) begin
            st_nxt.seek_tune_complete_flag = 1'b1;
            st_nxt.irqStat[`IRQ_STC] = 1'b1;
        end
        if (st_r.link == tuner_pkg::LINK_COMMIT) begin
            st_nxt.irqStat[`IRQ_GROUP] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{link: tuner_pkg::LINK_IDLE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign ack_o = st_r.ack;
    assign dat_o = st_r.rdData;
    assign thirdGeneralPinOe = (st_r.ctrl.gpioFn == `GPIO_FN_STEREO);
    assign thirdGeneralPinOut = thirdGeneralPinOe & st_r.stereo;
    // level interrupt, high while an unmasked event is pending
    assign irq = |(st_r.irqStat & st_r.irqMask);

    ////////////////////////////////////////////////////////////////////////
    // checks and covers beside the logic they guard
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic rdReq;
    assign rdReq = cyc_i & stb_i & ~we_i & ~st_r.ack;

    AST_STEREO_PIN: assert property (
        (st_r.ctrl.gpioFn == `GPIO_FN_STEREO) && stereoIn
        ##1 (st_r.ctrl.gpioFn == `GPIO_FN_STEREO) |-> thirdGeneralPinOut && thirdGeneralPinOe)
        else $error("third pin does not show stereo");
    AST_SIGNAL_STRENGTH_LEVEL_CAP: assert property (
        1'b1 |=> (st_r.signal_strength_level <= `SIGNAL_STRENGTH_LEVEL_MAX) && (st_r.signal_strength_level == satLevel($past(rssiIn))))
        else $error("signal level not saturated");
    AST_GRADE_POS: assert property (
        rdReq && idx == `IDX_REQUESTED_CHANNEL && st_r.ctrl.verbose
        |=> dat_o[15:10] == $past({st_r.grade}))
        else $error("grade field misplaced");
    AST_GRADE_HIDE: assert property (
        rdReq && idx == `IDX_REQUESTED_CHANNEL && !st_r.ctrl.verbose |=> dat_o[15:10] == 6'h00)
        else $error("grades shown outside verbose mode");
    AST_FREQ_WIDE: assert property (
        rdReq && idx == `IDX_FREQ && st_r.ctrl.band == 2'h0 && st_r.requested_channel == 10'h000
        |=> dat_o == 32'h0000_222e)
        else $error("wide band base wrong");
    AST_FREQ_LOW: assert property (
        rdReq && idx == `IDX_FREQ && st_r.ctrl.band == 2'h1 && st_r.requested_channel == 10'h001
        && st_r.ctrl.spacing == 2'h1 |=> dat_o == 32'h0000_1dba)
        else $error("low band frequency wrong");
    AST_REQUESTED_CHANNEL_FOLLOW: assert property (
        seekActive |=> st_r.requested_channel == $past(chanIn))
        else $error("tuned channel not updated during seek");
    AST_STC_SET: assert property (
        opDone |=> st_r.seek_tune_complete_flag ##1 (st_r.seek_tune_complete_flag || $past(wrHit)))
        else $error("complete flag not set");
    AST_BLOCK_A: assert property (
        rdReq && idx == `IDX_BLK_A |=> dat_o == {16'h0000, $past(st_r.blk[3])})
        else $error("block A readback wrong");
    AST_GROUP_ATOMIC: assert property (
        st_r.link == tuner_pkg::LINK_COMMIT |=> st_r.irqStat[`IRQ_GROUP]
        && st_r.blk == $past(st_r.shift[69:6]) && st_r.grade == $past(st_r.shift[5:0]))
        else $error("group not committed whole");
    AST_READ_QUIET: assert property (
        rdReq && !opDone && st_r.link != tuner_pkg::LINK_COMMIT
        |=> $stable(st_r.irqStat) && $stable(st_r.seek_tune_complete_flag) && $stable(st_r.blk))
        else $error("read changed stored state");
    AST_ACK_ONE: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack timing wrong");
    AST_ACK_ASKED: assert property (
        !(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without a request");
    AST_STC_CLEAR: assert property (
        wrHit && idx == `IDX_CTRL && st_r.ctrl.seek && !nextCtrl[`CTRL_SEEK]
        && !opDone |=> !st_r.seek_tune_complete_flag)
        else $error("complete flag not cleared by seek going low");
    AST_BAD_FRAME: assert property (
        st_r.link == tuner_pkg::LINK_SHIFT && !st_r.frmS[1] && st_r.bitCnt != `LINK_BITS
        |=> st_r.link == tuner_pkg::LINK_IDLE && $stable(st_r.blk) && $stable(st_r.grade))
        else $error("bad frame reached the block words");
    AST_GROUP_CLEAR: assert property (
        wrHit && idx == `IDX_IRQ_STAT && req.sel[0] && req.dat[`IRQ_GROUP]
        && st_r.link != tuner_pkg::LINK_COMMIT |=> !st_r.irqStat[`IRQ_GROUP])
        else $error("group-ready flag not cleared");
    AST_REQUESTED_CHANNEL_HOLD: assert property (
        !seekActive && !opDone |=> $stable(st_r.requested_channel))
        else $error("tuned channel moved while idle");
    AST_BLOCK_D: assert property (
        rdReq && idx == `IDX_BLK_D |=> dat_o == {16'h0000, $past(st_r.blk[0])})
        else $error("block D readback wrong");
    AST_PIN_OFF: assert property (
        st_r.ctrl.gpioFn != `GPIO_FN_STEREO |-> !thirdGeneralPinOe && !thirdGeneralPinOut)
        else $error("third pin driven outside its stereo function");

    COV_GROUP: cover property (st_r.link == tuner_pkg::LINK_COMMIT);
    COV_STC: cover property (opDone ##1 st_r.seek_tune_complete_flag);
    COV_REQUESTED_CHANNEL_READ: cover property (rdReq && idx == `IDX_REQUESTED_CHANNEL && st_r.ctrl.verbose);
    COV_IRQ: cover property (irq);
    COV_BAD_FRAME: cover property (st_r.link == tuner_pkg::LINK_SHIFT && !st_r.frmS[1]
        && st_r.bitCnt != `LINK_BITS);

endmodule : tuner_status_rds_readback
`default_nettype wire

// [block_link_source.sv]
// behavioural source of broadcast block groups on the link pins
// assumes the pins are sampled by an unrelated, faster clock
`timescale 1ns/1ps
`default_nettype none
module block_link_source (
    // link pins
    output var logic linkClk,
    output var logic linkData,
    output var logic linkFrame
);
    initial begin
        linkClk = 1'b0;
        linkData = 1'b0;
        linkFrame = 1'b0;
    end
    // 48 ns clock only inside a frame, msb first; n other than 70 makes a bad frame
    task automatic send(input logic [69:0] bits, input int n);
        linkFrame = 1'b1;
        #24;
        for (int i = 69; i > 69 - n; i--) begin
            linkData = bits[i];
            #12 linkClk = 1'b1;
            #24 linkClk = 1'b0;
            #12;
        end
        #24 linkFrame = 1'b0;
        // released data line shows the inverse of its last value
        linkData = ~linkData;
        #48;
    endtask : send
endmodule : block_link_source
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the tuner readback bank
// assumes wishbone classic master, core inputs and a link source partner
`timescale 1ns/1ps
`default_nettype none
`include "tuner_cfg.svh"
module tb_top;
    logic sysClk = 1'b0;
    logic rstN = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h3;
    logic [31:0] dat = 32'h0000_0000;
    logic ack;
    logic [31:0] rdData;
    logic stereoIn = 1'b0;
    logic [7:0] rssiIn = 8'h00;
    logic [9:0] chanIn = 10'h000;
    logic seekActive = 1'b0;
    logic opDone = 1'b0;
    logic linkClk, linkData, linkFrame, pinOut, pinOe, irq;
    int numErrors = 0;
    int samplesChecked = 0;
    logic [31:0] q;
    always #2 sysClk = ~sysClk;
    tuner_status_rds_readback uut (.sys_clk(sysClk), .rst_n(rstN), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .ack_o(ack), .dat_o(rdData),
        .stereoIn(stereoIn), .rssiIn(rssiIn), .chanIn(chanIn), .seekActive(seekActive),
        .opDone(opDone), .blkLinkClk(linkClk), .blkLinkData(linkData),
        .blkLinkFrame(linkFrame), .thirdGeneralPinOut(pinOut), .thirdGeneralPinOe(pinOe),
        .irq(irq));
    block_link_source src (.linkClk(linkClk), .linkData(linkData), .linkFrame(linkFrame));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finishTest();
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finishTest
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [5:0] idx, input logic [15:0] d);
        @(posedge sysClk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= {16'h0000, d};
        do begin
            @(posedge sysClk);
        end while (ack !== 1'b1);
        q = rdData;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge sysClk);
    endtask : wb
    task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input string name);
        wb(1'b0, idx, 16'h0000);
        chk(name, {16'h0000, exp}, q);
    endtask : rd
    task automatic waitIrq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 60) begin
            @(posedge sysClk);
            n++;
        end
        chk("irq raised", 32'h1, {31'h0, irq});
    endtask : waitIrq
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        rd(`IDX_STATUS, 16'h0000, "status reset");
        rd(`IDX_REQUESTED_CHANNEL, 16'h0000, "channel reset");
        for (int i = 0; i < 4; i++) rd(6'(`IDX_BLK_A + i), 16'h0000, "block reset");
        rd(6'h3f, 16'h0000, "unmapped");
        chk("pin oe reset", 32'h0, {31'h0, pinOe});
    endtask : testReset
    task automatic testStatus();
        stereoIn <= 1'b1;
        rssiIn <= 8'hc8;
        repeat (3) @(posedge sysClk);
        rd(`IDX_STATUS, 16'h014b, "stereo and level");
        wb(1'b1, `IDX_CTRL, 16'h0001);
        chk("third pin", 32'h3, {30'h0, pinOut, pinOe});
    endtask : testStatus
    task automatic testChannel();
        logic [15:0] exp [3] = '{16'h31ce, 16'h2580, 16'h2198};
        logic [15:0] cfg [3] = '{16'h0000, 16'h0050, 16'h00a0};
        seekActive <= 1'b1;
        chanIn <= 10'h0c8;
        repeat (3) @(posedge sysClk);
        seekActive <= 1'b0;
        chanIn <= 10'h005;
        rd(`IDX_REQUESTED_CHANNEL, 16'h00c8, "channel during seek");
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `IDX_CTRL, cfg[i]);
            rd(`IDX_FREQ, exp[i], "frequency");
        end
        for (int i = 0; i < 2; i++) begin
            seekActive <= 1'b1;
            chanIn <= 10'(i);
            @(posedge sysClk);
            seekActive <= 1'b0;
            wb(1'b1, `IDX_CTRL, cfg[i]);
            rd(`IDX_FREQ, (i == 0) ? 16'h222e : 16'h1dba, "frequency low channel");
        end
        chanIn <= 10'h12c;
        opDone <= 1'b1;
        @(posedge sysClk);
        opDone <= 1'b0;
        rd(`IDX_REQUESTED_CHANNEL, 16'h012c, "channel on finish");
        rd(`IDX_STATUS, 16'h414b, "complete flag");
        wb(1'b1, `IDX_CTRL, 16'h0100);
        chk("third pin off", 32'h0, {30'h0, pinOut, pinOe});
        wb(1'b1, `IDX_CTRL, 16'h0000);
        rd(`IDX_STATUS, 16'h014b, "complete cleared");
        opDone <= 1'b1;
        @(posedge sysClk);
        opDone <= 1'b0;
        wb(1'b1, `IDX_CTRL, 16'h0200);
        wb(1'b1, `IDX_CTRL, 16'h0000);
        rd(`IDX_STATUS, 16'h014b, "complete cleared by tune");
    endtask : testChannel
    task automatic testGroup();
        wb(1'b1, `IDX_IRQ_STAT, 16'h0003);
        wb(1'b1, `IDX_IRQ_MASK, 16'h0001);
        chk("irq clear", 32'h0, {31'h0, irq});
        src.send({64'h1234_5678_9abc_def0, 6'b01_10_11}, 70);
        waitIrq();
        rd(`IDX_BLK_A, 16'h1234, "block a");
        rd(`IDX_BLK_B, 16'h5678, "block b");
        rd(`IDX_BLK_C, 16'h9abc, "block c");
        rd(`IDX_BLK_D, 16'hdef0, "block d");
        rd(`IDX_REQUESTED_CHANNEL, 16'h012c, "grades hidden");
        rd(`IDX_STATUS, 16'h814b, "group ready");
        rd(`IDX_STATUS, 16'h814b, "read no side effect");
        wb(1'b1, `IDX_CTRL, 16'h0800);
        rd(`IDX_REQUESTED_CHANNEL, 16'h6d2c, "grades verbose");
        wb(1'b1, `IDX_IRQ_STAT, 16'h0001);
        rd(`IDX_STATUS, 16'h014b, "ready cleared");
        src.send({64'hffff_0000_ffff_0000, 6'h3f}, 69);
        repeat (30) @(posedge sysClk);
        rd(`IDX_BLK_A, 16'h1234, "bad frame dropped");
        chk("irq after bad frame", 32'h0, {31'h0, irq});
    endtask : testGroup
    task automatic testMidReset();
        rstN <= 1'b0;
        repeat (2) @(posedge sysClk);
        chk("read data in reset", 32'h0, rdData);
        rstN <= 1'b1;
        rd(`IDX_BLK_A, 16'h0000, "block after reset");
        rd(`IDX_REQUESTED_CHANNEL, 16'h0000, "channel after reset");
        rd(`IDX_STATUS, 16'h014b, "status after reset");
        chk("irq after reset", 32'h0, {31'h0, irq});
    endtask : testMidReset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sysClk);
        rstN <= 1'b1;
        testReset();
        testStatus();
        testChannel();
        testGroup();
        testMidReset();
        finishTest();
    end
    initial begin
        #100000;
        numErrors++;
        finishTest();
    end
endmodule : tb_top
`default_nettype wire
